// [verilog/stq_block.sv]
// statistics threshold engine, interrupt queue writer, countdown timers and ram window
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "stq_regs.svh"
module stq_block
    import stq_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `STQ_TICK_MUL * `STQ_TICK_BASE
)(
    input  wire logic        sys_clk,             // system clock, 200 MHz
    input  wire logic        arst_n,              // asynchronous reset, active low
    input  wire logic        psel,                // apb select
    input  wire logic        penable,             // apb access phase
    input  wire logic        pwrite,              // apb direction, high for write
    input  wire logic [19:0] paddr,               // apb byte address
    input  wire logic [31:0] pwdata,              // apb write data
    output logic      [31:0] prdata,              // apb read data
    output logic             pready,              // apb ready
    output logic             pslverr,             // apb error, unmapped address
    output logic             ram_en,              // ram strobe
    output logic             ram_we,              // ram write
    output logic      [15:0] ram_word_address,    // ram 32-bit word index
    output logic      [31:0] ram_wdata,           // ram write data
    input  wire logic [31:0] ram_rdata,           // ram read data, cycle after strobe
    input  wire logic        stat_event_valid,    // counter increment request
    input  wire logic [11:0] stat_event_index,    // port, channel, counter of request
    output logic             stat_event_ready,    // request taken when both high
    output logic             host_interrupt_one,  // set one timer status pending
    output logic             host_interrupt_two,  // set two timer status pending
    output logic      [31:0] insert_header_word   // header for cell insertion
);
    // ======================================================================
    // constants
    localparam logic [17:0] MP_TMR    = `STQ_MP_TMR_BASE;
    localparam logic [17:0] MP_INS    = `STQ_MP_INS_BASE;
    localparam logic [12:0] TICK_LAST = 13'(TICK_CYCLES - 1);
    // ======================================================================
    // state
    stq_state_t st;
    stq_state_t next_st;

    logic [17:0] mp;
    logic [3:0]  widx;
    logic        acc;
    logic        in_regs;
    logic        in_tmr;
    logic        in_ins;
    logic        in_ext;
    logic        tmr_wr;
    logic        evt_take;
    logic        eng_free;
    logic        tick;
    logic [15:0] expired;
    logic [7:0]  clr1;
    logic [7:0]  clr2;
    logic [31:0] chk_count;
    logic        chk_hit;

    // address decode, host_bus_address is the byte address halved
    assign mp       = paddr[18:1];
    assign widx     = paddr[5:2];
    assign acc      = psel && penable && !st.pready && (st.bus == BUS_IDLE);
    assign in_regs  = mp < `STQ_MP_REGS_END;
    assign in_tmr   = mp[17:5] == MP_TMR[17:5];
    assign in_ins   = mp[17:5] == MP_INS[17:5];
    assign in_ext   = !paddr[19] && !in_regs && !in_tmr && !in_ins;
    assign tmr_wr   = acc && !paddr[19] && in_tmr && pwrite;
    assign evt_take = stat_event_valid && st.evt_ready;
    assign eng_free = (st.eng == ENG_IDLE) && !evt_take;
    assign tick     = st.presc == TICK_LAST;

    stq_thr_check u_chk (
        .count_entry      (st.cnt_entry),
        .thres_entry      (ram_rdata),
        .next_count_entry (chk_count),
        .hit              (chk_hit)
    );

    // ======================================================================
    // next state
    always_comb begin
        next_st         = st;
        expired         = 16'h0000;
        clr1            = 8'h00;
        clr2            = 8'h00;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.ram_en  = 1'b0;
        next_st.ram_we  = 1'b0;

        // prescaler runs freely so every timer shares one tick phase
        next_st.presc = tick ? 13'h0000 : 13'(st.presc + 13'h0001);

        // countdown; expiry is the decrement from zero, which parks at 7FFFH
        for (int i = 0; i < 16; i++) begin
            if (tick && st.timers[i][`STQ_TEN_BIT] &&
                ((i >= `STQ_TMRS_PER_SET) ? st.set_one_en : st.set_two_en)) begin
                if (st.timers[i][`STQ_TVAL_MSB:0] == `STQ_TMR_ZERO) begin
                    next_st.timers[i] = {1'b0, `STQ_TMR_REST};
                    expired[i]        = 1'b1;
                end else begin
                    next_st.timers[i][`STQ_TVAL_MSB:0] =
                        15'(st.timers[i][`STQ_TVAL_MSB:0] - 15'h0001);
                end
            end
        end

        // host bus; a software write to a timer overrides the tick update
        unique case (st.bus)
            BUS_IDLE: begin
                if (acc) begin
                    if (paddr[19]) begin
                        next_st.pready  = 1'b1;
                        next_st.pslverr = 1'b1;
                    end else if (in_regs) begin
                        next_st.pready = 1'b1;
                        next_st.prdata = 32'h00000000;
                        case (mp)
                            `STQ_MP_CTRL_ONE: begin
                                if (pwrite) begin
                                    next_st.set_one_en = pwdata[0];
                                end
                                next_st.prdata[0] = st.set_one_en;
                            end
                            `STQ_MP_CTRL_TWO: begin
                                if (pwrite) begin
                                    next_st.set_two_en = pwdata[0];
                                end
                                next_st.prdata[0] = st.set_two_en;
                            end
                            `STQ_MP_STAT_ONE: begin
                                if (pwrite) begin
                                    clr1 = pwdata[7:0];
                                end
                                next_st.prdata[7:0] = st.int_status_one;
                            end
                            `STQ_MP_STAT_TWO: begin
                                if (pwrite) begin
                                    clr2 = pwdata[7:0];
                                end
                                next_st.prdata[7:0] = st.int_status_two;
                            end
                            default: begin
                                next_st.pslverr = 1'b1;
                            end
                        endcase
                    end else if (in_tmr) begin
                        next_st.pready = 1'b1;
                        if (pwrite) begin
                            next_st.timers[widx] = pwdata[15:0];
                        end
                        next_st.prdata = {16'h0000, st.timers[widx]};
                    end else if (in_ins) begin
                        next_st.pready = 1'b1;
                        if (pwrite) begin
                            next_st.ins_buf[widx] = pwdata;
                        end
                        next_st.prdata = st.ins_buf[widx];
                    end else if (eng_free) begin
                        // ram regions: word index is the host address halved again
                        next_st.ram_en    = 1'b1;
                        next_st.ram_we    = pwrite;
                        next_st.ram_addr  = paddr[17:2];
                        next_st.ram_wdata = pwdata;
                        next_st.bus       = BUS_RAM_A;
                    end
                end
            end
            BUS_RAM_A: begin
                next_st.bus = BUS_RAM_B;
            end
            BUS_RAM_B: begin
                if (!pwrite) begin
                    next_st.prdata = ram_rdata;
                end
                next_st.pready = 1'b1;
                next_st.bus    = BUS_IDLE;
            end
        endcase

        // threshold engine: read counter, read threshold, write back, append
        unique case (st.eng)
            ENG_IDLE: begin
                if (evt_take) begin
                    next_st.evt_idx  = stat_event_index;
                    next_st.ram_en   = 1'b1;
                    next_st.ram_addr = {`STQ_RW_CNT_BASE, stat_event_index};
                    next_st.eng      = ENG_CNT_A;
                end
            end
            ENG_CNT_A: begin
                next_st.eng = ENG_CNT_B;
            end
            ENG_CNT_B: begin
                next_st.cnt_entry = ram_rdata;
                next_st.ram_en    = 1'b1;
                next_st.ram_addr  = {`STQ_RW_THR_BASE, st.evt_idx};
                next_st.eng       = ENG_THR_A;
            end
            ENG_THR_A: begin
                next_st.eng = ENG_THR_B;
            end
            ENG_THR_B: begin
                next_st.ram_en    = 1'b1;
                next_st.ram_we    = 1'b1;
                next_st.ram_addr  = {`STQ_RW_CNT_BASE, st.evt_idx};
                next_st.ram_wdata = chk_count;
                next_st.eng       = chk_hit ? ENG_QWR : ENG_IDLE;
            end
            ENG_QWR: begin
                next_st.ram_en    = 1'b1;
                next_st.ram_we    = 1'b1;
                next_st.ram_addr  = {`STQ_RW_Q_BASE, st.q_wptr};
                next_st.ram_wdata = 32'h00000000;
                next_st.ram_wdata[`STQ_QNE_BIT]     = 1'b1;
                next_st.ram_wdata[`STQ_QIDX_MSB:0]  = st.evt_idx;
                next_st.q_wptr    = 12'(st.q_wptr + 12'h001);
                next_st.eng       = ENG_IDLE;
            end
            default: begin
                next_st.eng = ENG_IDLE;
            end
        endcase

        // events are refused while the host bus holds or wants the ram
        next_st.evt_ready = (next_st.eng == ENG_IDLE) && (next_st.bus == BUS_IDLE) && !psel;

        // status: write-one-to-clear, a same-cycle expiry wins over the clear
        next_st.int_status_one = (st.int_status_one & ~clr1) | expired[15:8];
        next_st.int_status_two = (st.int_status_two & ~clr2) | expired[7:0];
        next_st.irq1 = |next_st.int_status_one;
        next_st.irq2 = |next_st.int_status_two;
    end

    // ======================================================================
    // registers; group enables start off so no timer runs before set-up
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs come straight from the state flops
    assign prdata             = st.prdata;
    assign pready             = st.pready;
    assign pslverr            = st.pslverr;
    assign ram_en             = st.ram_en;
    assign ram_we             = st.ram_we;
    assign ram_word_address   = st.ram_addr;
    assign ram_wdata          = st.ram_wdata;
    assign stat_event_ready   = st.evt_ready;
    assign host_interrupt_one = st.irq1;
    assign host_interrupt_two = st.irq2;
    assign insert_header_word = st.ins_buf[`STQ_HDR_WORD];

    // ======================================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    thr_addr_a: assert property (
        (st.eng == ENG_THR_A) |-> st.ram_en && st.ram_addr == {`STQ_RW_THR_BASE, st.evt_idx})
        else $error("threshold read address wrong");

    thr_act_a: assert property (
        (st.eng == ENG_THR_B && !ram_rdata[`STQ_FLAG_BIT]) |=> st.eng != ENG_QWR)
        else $error("inactive threshold produced queue entry");

    thr_max_a: assert property (
        (st.eng == ENG_THR_B && ram_rdata[`STQ_VAL31_MSB:0] > `STQ_CNT_MAX)
        |=> st.eng != ENG_QWR)
        else $error("unreachable threshold produced queue entry");

    qent_fmt_a: assert property (
        (st.eng == ENG_QWR) |=> st.ram_we && st.ram_wdata[`STQ_QIDX_MSB:0] == $past(st.evt_idx)
        && st.ram_wdata[31:`STQ_QHI_LSB] == 16'h0000)
        else $error("queue entry layout wrong");

    qne_flag_a: assert property (
        (st.eng == ENG_QWR) |=> st.ram_wdata[`STQ_QNE_BIT])
        else $error("queue entry lacks not-empty flag");

    tmr_map_a: assert property (
        (acc && !paddr[19] && in_tmr) |=> st.pready && !st.ram_en && !st.pslverr)
        else $error("timer access not answered locally");

    tmr_irq_a: assert property (
        (|expired[15:8]) |=> host_interrupt_one
        && st.int_status_one == (($past(st.int_status_one) & ~$past(clr1)) | $past(expired[15:8])))
        else $error("set one expiry not on interrupt one");

    tmr_stop_a: assert property (
        (expired[0] && !tmr_wr) |=> !st.timers[0][`STQ_TEN_BIT])
        else $error("expired timer still enabled");

    tmr_tick_a: assert property (
        (tick && st.timers[0][`STQ_TEN_BIT] && st.set_two_en && !tmr_wr
         && st.timers[0][`STQ_TVAL_MSB:0] != `STQ_TMR_ZERO)
        |=> st.timers[0][`STQ_TVAL_MSB:0] == 15'($past(st.timers[0][`STQ_TVAL_MSB:0]) - 15'h0001)
            && st.presc == 13'h0000)
        else $error("timer decrement wrong");

    tmr_rest_a: assert property (
        (expired[0] && !tmr_wr) |=> st.timers[0][`STQ_TVAL_MSB:0] == `STQ_TMR_REST && st.int_status_two[0]
                                    && host_interrupt_two)
        else $error("expiry rest value or status wrong");

    tmr_read_a: assert property (
        (acc && !paddr[19] && in_tmr && !pwrite) |=> st.prdata[31:`STQ_QHI_LSB] == 16'h0000)
        else $error("timer upper half not zero");

    grp_off_a: assert property (
        (!st.set_one_en |-> expired[15:8] == 8'h00) and (!st.set_two_en |-> expired[7:0] == 8'h00))
        else $error("disabled timer set expired");

    ins_hdr_a: assert property (
        (acc && !paddr[19] && in_ins && pwrite && widx == `STQ_HDR_WORD)
        |=> insert_header_word == $past(pwdata))
        else $error("insertion header not stored");

    ext_map_a: assert property (
        (acc && in_ext && eng_free) |=> st.ram_en && st.ram_addr == $past(paddr[17:2])
        ##2 st.pready)
        else $error("ram region access wrong");

    gen_once_a: assert property (
        (st.eng == ENG_THR_B && st.cnt_entry[`STQ_FLAG_BIT]) |=> st.eng == ENG_IDLE
        && st.ram_wdata[`STQ_FLAG_BIT])
        else $error("reported counter reported again");

    cnt_sat_a: assert property (
        (st.eng == ENG_THR_B) |=> st.ram_we && st.ram_wdata[`STQ_VAL31_MSB:0] <= `STQ_CNT_MAX)
        else $error("counter exceeded maximum");

    q_append_a: assert property (
        (st.eng == ENG_THR_B && chk_hit) |=> st.ram_wdata[`STQ_FLAG_BIT] && st.eng == ENG_QWR
        ##1 st.q_wptr == 12'($past(st.q_wptr, 2) + 12'h001))
        else $error("threshold hit did not append entry");

    expire_c:  cover property (|expired);
    qwrite_c:  cover property (st.eng == ENG_QWR);
    ramread_c: cover property (st.bus == BUS_RAM_B && !pwrite);
    slverr_c:  cover property (st.pready && st.pslverr);
endmodule

// [verilog/stq_regs.svh]
// address map, field positions and timing constants of the statistics/queue/timer block
`ifndef STQ_REGS_SVH
`define STQ_REGS_SVH

// ==========================================================================
// host address map (host_bus_address units, one 32-bit entry per two units)
`define STQ_MP_REGS_END   18'h20000
`define STQ_MP_CTRL_ONE   18'h00000
`define STQ_MP_CTRL_TWO   18'h00002
`define STQ_MP_STAT_ONE   18'h00004
`define STQ_MP_STAT_TWO   18'h00006
`define STQ_MP_TMR_BASE   18'h26000
`define STQ_MP_INS_BASE   18'h26020

// ==========================================================================
// ram_word_address region prefixes for the engine's own accesses
`define STQ_RW_CNT_BASE   4'h0
`define STQ_RW_THR_BASE   4'h1
`define STQ_RW_Q_BASE     4'h2

// ==========================================================================
// entry fields
`define STQ_CNT_MAX       31'h40000000
`define STQ_FLAG_BIT      31
`define STQ_VAL31_MSB     30
`define STQ_QNE_BIT       15
`define STQ_QIDX_MSB      11
`define STQ_QHI_LSB       16
`define STQ_TEN_BIT       15
`define STQ_TVAL_MSB      14
`define STQ_TMR_REST      15'h7FFF
`define STQ_TMR_ZERO      15'h0000
`define STQ_TMRS_PER_SET  8
`define STQ_HDR_WORD      4'h0

// ==========================================================================
// timer tick: 12 x 512 system clock periods
`define STQ_TICK_MUL      12
`define STQ_TICK_BASE     512

`endif

// [verilog/stq_pkg.sv]
// types shared by the statistics/queue/timer block
package stq_pkg;
    `include "stq_regs.svh"

    // bus side: idle, ram access issued, ram data present
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_RAM_A = 2'b01,
        BUS_RAM_B = 2'b11
    } stq_bus_st_t;

    // threshold engine, gray along counter read, threshold read, queue write
    typedef enum logic [2:0] {
        ENG_IDLE  = 3'b000,
        ENG_CNT_A = 3'b001,
        ENG_CNT_B = 3'b011,
        ENG_THR_A = 3'b010,
        ENG_THR_B = 3'b110,
        ENG_QWR   = 3'b111
    } stq_eng_st_t;

    typedef struct packed {
        stq_bus_st_t        bus;
        stq_eng_st_t        eng;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic               ram_en;
        logic               ram_we;
        logic [15:0]        ram_addr;
        logic [31:0]        ram_wdata;
        logic               evt_ready;
        logic [11:0]        evt_idx;
        logic [31:0]        cnt_entry;
        logic [11:0]        q_wptr;
        logic               set_one_en;
        logic               set_two_en;
        logic [7:0]         int_status_one;
        logic [7:0]         int_status_two;
        logic               irq1;
        logic               irq2;
        logic [12:0]        presc;
        logic [15:0][15:0]  timers;
        logic [15:0][31:0]  ins_buf;
    } stq_state_t;
endpackage

// [verilog/stq_thr_check.sv]
// saturating counter increment and threshold match for one statistics counter
`timescale 1ns/1ps
`include "stq_regs.svh"
module stq_thr_check
    import stq_pkg::*;
(
    input  wire logic [31:0] count_entry,      // counter entry as read from ram
    input  wire logic [31:0] thres_entry,      // threshold entry as read from ram
    output logic      [31:0] next_count_entry, // entry to write back
    output logic             hit               // queue entry must be produced
);
    logic        sat;
    logic [30:0] inc;
    logic        reachable;

    // counter stops at its maximum instead of wrapping
    assign sat = count_entry[`STQ_VAL31_MSB:0] >= `STQ_CNT_MAX;
    assign inc = sat ? `STQ_CNT_MAX : 31'(count_entry[`STQ_VAL31_MSB:0] + 31'h00000001);

    // thresholds past the maximum can never be reached, so they are ignored
    assign reachable = thres_entry[`STQ_VAL31_MSB:0] <= `STQ_CNT_MAX;

    // active, not yet reported and equal: report once
    assign hit = thres_entry[`STQ_FLAG_BIT] && !count_entry[`STQ_FLAG_BIT] && reachable
                 && (inc == thres_entry[`STQ_VAL31_MSB:0]);
    assign next_count_entry = {count_entry[`STQ_FLAG_BIT] | hit, inc};
endmodule

// [verif/stq_ram_model.sv]
// behavioural synchronous ram on the far side of the block's ram port
`timescale 1ns/1ps
module stq_ram_model (
    input  wire logic        sys_clk,          // system clock
    input  wire logic        ram_en,           // strobe
    input  wire logic        ram_we,           // write qualifier
    input  wire logic [15:0] ram_word_address, // word index
    input  wire logic [31:0] ram_wdata,        // write data
    output logic      [31:0] ram_rdata         // read data, cycle after strobe
);
    // ==========================================
    // storage has no reset value, as in the real array
    logic [31:0] mem [0:65535];
    initial ram_rdata = 32'h0;
    // outside a read data cycle the bus toggles so stale data never looks valid
    always @(posedge sys_clk) begin
        if (ram_en && ram_we)
            mem[ram_word_address] <= ram_wdata;
        ram_rdata <= (ram_en && !ram_we) ? mem[ram_word_address] : ~ram_rdata;
    end
endmodule

// [verif/tb_stq_block.sv]
// self-checking testbench of the statistics/queue/timer block
`timescale 1ns/1ps
module tb_stq_block;
    import stq_pkg::*;
    logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, ev_v = 0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0, prdata, ram_wdata, ram_rdata, hdr, rd, seed;
    logic [11:0] ev_i = 12'h0, i1;
    logic [15:0] ram_a;
    logic pready, pslverr, ram_en, ram_we, ev_r, irq1, irq2, er;
    int bad_count = 0, n_checks = 0;
    // ==========================================
    // design and its ram
    stq_block #(.TICK_CYCLES(8)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ram_en(ram_en), .ram_we(ram_we),
        .ram_word_address(ram_a), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .stat_event_valid(ev_v), .stat_event_index(ev_i), .stat_event_ready(ev_r),
        .host_interrupt_one(irq1), .host_interrupt_two(irq2), .insert_header_word(hdr));
    stq_ram_model ram (.sys_clk(sys_clk), .ram_en(ram_en), .ram_we(ram_we),
        .ram_word_address(ram_a), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
    always #2.5 sys_clk = ~sys_clk;
    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] q_entry(input logic [11:0] i);
        return {16'h0, 1'b1, 3'b0, i};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // apb transfer: setup, then access held until pready at an edge; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // one counter event, held until taken, then the engine is left to finish
    task automatic ev(input logic [11:0] i);
        @(posedge sys_clk);
        ev_v <= 1'b1;
        ev_i <= i;
        do @(posedge sys_clk); while (ev_r !== 1'b1);
        ev_v <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    // ==========================================
    // main sequence
    initial begin
        seed = lfsr(32'd36);
        i1   = seed[11:0];
        // the ram has no reset value, so every word the engine touches is set up first
        ram.mem[{4'h0, i1}]  = 32'h4;
        ram.mem[{4'h1, i1}]  = 32'h80000005;
        ram.mem[{4'h0, ~i1}] = 32'h40000000;
        ram.mem[{4'h1, ~i1}] = 32'hC0000001;
        ram.mem[16'h2000]    = 32'h0;
        ram.mem[16'h2001]    = 32'h0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        apb(0, 20'h0, 0);
        chk(rd, 32'h0);
        apb(0, 20'h10, 0);
        chk(er, 1'b1);
        apb(0, 20'h80000, 0);
        chk(er, 1'b1);
        // set two timer counts 2,1,0 then rests; set one is halted by its group
        apb(1, 20'h4C000, 32'h8002);
        apb(1, 20'h4C020, 32'h8003);
        apb(1, 20'h4, 1);
        repeat (60) @(posedge sys_clk);
        apb(0, 20'h4C000, 0);
        chk(rd, 32'h00007FFF);
        apb(0, 20'h4C020, 0);
        chk(rd, 32'h8003);
        chk(irq2, 1'b1);
        chk(irq1, 1'b0);
        apb(0, 20'hC, 0);
        chk(rd, 32'h1);
        apb(1, 20'hC, 1);
        repeat (3) @(posedge sys_clk);
        chk(irq2, 1'b0);
        // releasing set one lets the held timer 8 run out on interrupt one
        apb(1, 20'h0, 1);
        repeat (60) @(posedge sys_clk);
        chk(irq1, 1'b1);
        apb(0, 20'h4C020, 0);
        chk(rd, 32'h00007FFF);
        apb(0, 20'h8, 0);
        chk(rd, 32'h1);
        // insertion header, random payload words, an extraction word through the ram path
        seed = lfsr(seed);
        apb(1, 20'h4C040, seed);
        apb(0, 20'h4C040, 0);
        chk(rd, seed);
        chk(hdr, seed);
        for (int k = 1; k < 9; k++) begin
            seed = lfsr(seed);
            apb(1, 20'h4C040 + 20'(4 * k), seed);
            apb(0, 20'h4C040 + 20'(4 * k), 0);
            chk(rd, seed);
        end
        apb(1, 20'h4C080, ~seed);
        apb(0, 20'h4C080, 0);
        chk(rd, ~seed);
        chk(ram.mem[16'h3020], ~seed);
        // channel header of the segmentation region, cell and word bits zero
        apb(1, {4'h5, i1[11:4], 8'h00}, seed);
        chk(ram.mem[{2'b01, i1[11:4], 6'h00}], seed);
        // threshold hit, repeat on the reported counter, saturated counter
        ev(i1);
        chk(ram.mem[{4'h0, i1}], 32'h80000005);
        chk(ram.mem[16'h2000], q_entry(i1));
        ev(i1);
        chk(ram.mem[{4'h0, i1}], 32'h80000006);
        ev(~i1);
        chk(ram.mem[{4'h0, ~i1}], 32'h40000000);
        chk(ram.mem[16'h2001], 32'h0);
        finish_test();
    end
endmodule
